// ===== include/supply_monitor_map.vh
// Purpose: offsets, field positions, reset values and timing counts for
//          the supply monitor block
// Assumes: 100 MHz system clock, 8-bit register port
// Notes:   offsets are local to this block
`ifndef SUPPLY_MONITOR_MAP_VH
`define SUPPLY_MONITOR_MAP_VH

// ===========================================================
// register offsets
`define SM_ADDR_W 2
`define SM_OFF_CONTROL 2'h0
`define SM_OFF_IRQ_STATUS 2'h1
`define SM_OFF_IRQ_MASK 2'h2

// ===========================================================
// control register fields
`define SM_CTRL_RESET 8'h00
`define SM_CTRL_WMASK 8'h17
`define SM_BIT_FLAG 5
`define SM_BIT_ENABLE 4
`define SM_SEL_HI 2
`define SM_SEL_LO 0

// ===========================================================
// interrupt status / mask fields
`define SM_BIT_IRQ_REQ 0
`define SM_BIT_IRQ_WAKE 1
`define SM_IRQ_W 2
`define SM_IRQ_RESET 2'h0

// ===========================================================
// timing: irq_assert_delay in ns and its cycle count at 10 ns
`define SM_CLK_PERIOD_NS 10
`define SM_IRQ_DELAY_NS 1000
`define SM_IRQ_DELAY_CYC (`SM_IRQ_DELAY_NS / `SM_CLK_PERIOD_NS)
`define SM_CNT_W 8

`endif

// ===== rtl/level_sync.v
// Purpose: two-flop synchroniser for the comparator output
// Assumes: one system clock
// Notes:   first flop feeds only the second
`timescale 1ns/10ps
module level_sync (
   sys_clk,
   rst,
   async_in,
   sync_out
);
   input wire sys_clk;
   input wire rst;
   input wire async_in;
   output wire sync_out;

   reg meta_ff;
   reg stable_ff;

   // ===========================================================
   // synchroniser stages
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         meta_ff <= 1'b0;
         stable_ff <= 1'b0;
      end else begin
         meta_ff <= async_in;
         stable_ff <= meta_ff;
      end
   end

   assign sync_out = stable_ff;
endmodule

// ===== rtl/irq_delay.v
// Purpose: holds off the interrupt request until low supply has lasted
//          the assert delay
// Assumes: level input already synchronous
// Notes:   a drop of the level restarts the wait
`timescale 1ns/10ps
`include "supply_monitor_map.vh"
module irq_delay (
   sys_clk,
   rst,
   low_level,
   fire
);
   input wire sys_clk;
   input wire rst;
   input wire low_level;
   output wire fire;

   reg [`SM_CNT_W-1:0] cnt_ff;
   reg done_ff;
   wire [`SM_CNT_W-1:0] last_cnt;
   // the cycle count is a plain integer; cut it to the counter on purpose
   localparam [31:0] LAST_FULL = `SM_IRQ_DELAY_CYC - 1;

   assign last_cnt = LAST_FULL[`SM_CNT_W-1:0];

   // ===========================================================
   // delay counter
   // restarting on every drop tolerates a chattering level
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt_ff <= {`SM_CNT_W{1'b0}};
         done_ff <= 1'b0;
      end else if (!low_level) begin
         cnt_ff <= {`SM_CNT_W{1'b0}};
         done_ff <= 1'b0;
      end else if (!done_ff) begin
         if (cnt_ff == last_cnt)
            done_ff <= 1'b1;
         else
            cnt_ff <= cnt_ff + 8'h01;
      end
   end

   // one pulse per completed low period
   assign fire = low_level && !done_ff && (cnt_ff == last_cnt);
endmodule

// ===== rtl/supply_monitor.v
// Purpose: control register, detect flag, delayed interrupt request and
//          wake-up for the supply low-voltage monitor
// Assumes: comparator output is asynchronous; register port is 8 bits
// Notes:   analog comparator and reference sit outside this block
`timescale 1ns/10ps
`include "supply_monitor_map.vh"

module supply_monitor (
   sys_clk,
   rst,
   reg_addr,
   reg_wdata,
   reg_wr,
   reg_rd,
   reg_rdata,
   comparator_low,
   power_down,
   detector_on,
   threshold_select,
   wake_up,
   irq
);
   input wire sys_clk;
   input wire rst;
   input wire [`SM_ADDR_W-1:0] reg_addr;
   input wire [7:0] reg_wdata;
   input wire reg_wr;
   input wire reg_rd;
   output reg [7:0] reg_rdata;
   input wire comparator_low;
   input wire power_down;
   output wire detector_on;
   output wire [2:0] threshold_select;
   output wire wake_up;
   output wire irq;

   reg monitor_enable_ff;
   reg [2:0] threshold_ff;
   reg [`SM_IRQ_W-1:0] status_ff;
   reg [`SM_IRQ_W-1:0] mask_ff;
   reg wake_ff;
   reg [7:0] nxt_rdata;
   reg [`SM_IRQ_W-1:0] nxt_status;
   wire low_sync;
   wire low_supply_flag;
   wire delay_fire;
   wire req_rise;

   // ===========================================================
   // write decode
   function is_wr;
      input wr;
      input [`SM_ADDR_W-1:0] addr;
      input [`SM_ADDR_W-1:0] off;
      begin
         is_wr = wr && (addr == off);
      end
   endfunction

   // ===========================================================
   // comparator input
   level_sync u_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .async_in(comparator_low),
      .sync_out(low_sync)
   );

   // flag is meaningless while the detector is off, so force it low
   assign low_supply_flag = monitor_enable_ff && low_sync;

   irq_delay u_delay (
      .sys_clk(sys_clk),
      .rst(rst),
      .low_level(low_supply_flag),
      .fire(delay_fire)
   );

   // ===========================================================
   // control register
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         monitor_enable_ff <= 1'b0;
         threshold_ff <= 3'h0;
      end else if (is_wr(reg_wr, reg_addr, `SM_OFF_CONTROL)) begin
         monitor_enable_ff <= reg_wdata[`SM_BIT_ENABLE];
         threshold_ff <= reg_wdata[`SM_SEL_HI:`SM_SEL_LO];
      end
   end

   // power_down is deliberately not used here: enable alone rules
   assign detector_on = monitor_enable_ff;
   assign threshold_select = threshold_ff;

   // ===========================================================
   // interrupt status: set wins over write-one-to-clear
   assign req_rise = delay_fire && !status_ff[`SM_BIT_IRQ_REQ];

   always @* begin
      nxt_status = status_ff;
      if (is_wr(reg_wr, reg_addr, `SM_OFF_IRQ_STATUS))
         nxt_status = status_ff & ~reg_wdata[`SM_IRQ_W-1:0];
      if (delay_fire)
         nxt_status[`SM_BIT_IRQ_REQ] = 1'b1;
      if (req_rise && power_down)
         nxt_status[`SM_BIT_IRQ_WAKE] = 1'b1;
   end

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         status_ff <= `SM_IRQ_RESET;
         mask_ff <= `SM_IRQ_RESET;
         wake_ff <= 1'b0;
      end else begin
         status_ff <= nxt_status;
         if (is_wr(reg_wr, reg_addr, `SM_OFF_IRQ_MASK))
            mask_ff <= reg_wdata[`SM_IRQ_W-1:0];
         // mask does not gate the wake-up
         wake_ff <= req_rise && power_down;
      end
   end

   assign wake_up = wake_ff;
   assign irq = |(status_ff & mask_ff);

   // ===========================================================
   // read path
   always @* begin
      nxt_rdata = 8'h00;
      case (reg_addr)
         `SM_OFF_CONTROL: begin
            // bits 7, 6, 3 stay zero
            nxt_rdata[`SM_BIT_FLAG] = low_supply_flag;
            nxt_rdata[`SM_BIT_ENABLE] = monitor_enable_ff;
            nxt_rdata[`SM_SEL_HI:`SM_SEL_LO] = threshold_ff;
         end
         `SM_OFF_IRQ_STATUS: nxt_rdata[`SM_IRQ_W-1:0] = status_ff;
         `SM_OFF_IRQ_MASK: nxt_rdata[`SM_IRQ_W-1:0] = mask_ff;
         default: nxt_rdata = 8'h00;
      endcase
   end

   always @(posedge sys_clk or posedge rst) begin
      if (rst)
         reg_rdata <= 8'h00;
      else if (reg_rd)
         reg_rdata <= nxt_rdata;
      else
         reg_rdata <= 8'h00;
   end
endmodule

// ===== verif/supply_monitor_properties.sv
// Purpose: port-level checks for supply_monitor
// Assumes: one clock, asynchronous active-high reset
// Notes:   bound into every supply_monitor instance at the foot
`timescale 1ns/10ps
module supply_monitor_chk (
   input wire sys_clk,
   input wire rst,
   input wire [1:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_rdata,
   input wire comparator_low,
   input wire power_down,
   input wire detector_on,
   input wire [2:0] threshold_select,
   input wire wake_up,
   input wire irq
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // ==========================================================
   // register port
   ctrl_bits_a: assert property (reg_rdata[7:6] == 2'h0 && !reg_rdata[3])
      else $error("unused bits read as one");
   idle_read_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside its cycle");
   enable_wr_a: assert property ($past(reg_wr && reg_addr == 2'h0) |->
      detector_on == $past(reg_wdata[4])) else $error("enable not taken");
   sel_wr_a: assert property ($past(reg_wr && reg_addr == 2'h0) |->
      threshold_select == $past(reg_wdata[2:0])) else $error("select lost");
   // sleep must not switch the detector, only a write may
   enable_hold_a: assert property (!$past(reg_wr) |-> $stable(detector_on))
      else $error("enable changed without write");
   // ==========================================================
   // wake-up
   wake_once_a: assert property (wake_up |=> !wake_up)
      else $error("wake longer than one cycle");
   wake_sleep_a: assert property (wake_up |-> $past(power_down))
      else $error("wake while awake");
   wake_delay_a: assert property (wake_up |->
      $past(comparator_low, 90) && $past(comparator_low, 5))
      else $error("wake before low supply lasted");
endmodule
bind supply_monitor supply_monitor_chk supply_monitor_chk_i (.*);

// ===== verif/supply_monitor_tb_top.sv
// Purpose: self-checking bench for supply_monitor
// Assumes: 100 MHz clock, register read data one cycle after strobe
// Notes:   comparator is driven as a clean level by the bench
`timescale 1ns/10ps
module supply_monitor_tb_top;
   logic sys_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0;
   logic comparator_low = 0, power_down = 0;
   logic [1:0] reg_addr = 2'h0;
   logic [7:0] reg_wdata = 8'h00, reg_rdata;
   logic detector_on, wake_up, irq;
   logic [2:0] threshold_select;
   int miscompares = 0, checks = 0, n;
   // write value beside expected read-back
   logic [15:0] rows [8] = '{16'hf810, 16'he901, 16'hfa12, 16'heb03,
      16'hfc14, 16'hed05, 16'hfe16, 16'hef07};
   always #5 sys_clk = ~sys_clk;
   supply_monitor supply_monitor_i (.*);
   // ==========================================================
   // helpers
   task test_done;
      if (miscompares == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task cmp(string s, logic [7:0] e, logic [7:0] g);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %s exp %h got %h", s, e, g);
      end
   endtask
   task wr(logic [1:0] a, logic [7:0] v);
      @(posedge sys_clk);
      reg_wr <= 1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge sys_clk);
      reg_wr <= 0;
   endtask
   task rd(logic [1:0] a, logic [7:0] e);
      @(posedge sys_clk);
      reg_rd <= 1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 0;
      @(negedge sys_clk);
      cmp("rdata", e, reg_rdata);
   endtask
   // bounded wait; comparator goes low at the first edge
   task wake_wait;
      @(posedge sys_clk);
      comparator_low <= 1;
      // look at the falling edge, where the one-cycle pulse has settled
      for (n = 0; n < 200 && wake_up !== 1'b1; n++)
         @(negedge sys_clk);
      if (n == 200) begin
         miscompares++;
         test_done;
      end
      cmp("delay", 8'h01, 8'(n >= 100 && n <= 106));
   endtask
   // ==========================================================
   // sequence
   initial begin
      repeat (5) @(posedge sys_clk);
      rst <= 0;
      for (int a = 0; a < 4; a++)
         rd(a[1:0], 8'h00);
      wr(2'h3, 8'hff);
      rd(2'h3, 8'h00);
      foreach (rows[i]) begin
         wr(2'h0, rows[i][15:8]);
         rd(2'h0, rows[i][7:0]);
         cmp("sel", 8'(rows[i][10:8]), 8'(threshold_select));
         cmp("en", 8'(rows[i][12]), 8'(detector_on));
      end
      wr(2'h0, 8'h10);
      wr(2'h2, 8'h01);
      comparator_low <= 1;
      repeat (3) @(posedge sys_clk);
      rd(2'h0, 8'h30);
      // short low runs must never reach the request
      repeat (3) begin
         comparator_low <= ~comparator_low;
         repeat (40) @(posedge sys_clk);
      end
      rd(2'h1, 8'h00);
      power_down <= 1;
      wake_wait;
      cmp("irq", 8'h01, 8'(irq));
      rd(2'h1, 8'h03);
      cmp("en", 8'h01, 8'(detector_on));
      wr(2'h1, 8'h01);
      rd(2'h1, 8'h02);
      wr(2'h2, 8'h00);
      wr(2'h1, 8'h02);
      comparator_low <= 0;
      repeat (10) @(posedge sys_clk);
      wake_wait;
      cmp("irq", 8'h00, 8'(irq));
      rst <= 1;
      repeat (2) @(posedge sys_clk);
      rst <= 0;
      rd(2'h0, 8'h00);
      cmp("en", 8'h00, 8'(detector_on));
      test_done;
   end
endmodule
